// [src/sgp_pkg.sv]
// Constants shared by the six-pin general I/O port: offsets, fields, resets, timing.
`default_nettype none
package sgp_pkg;

   // Bus and port widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PIN_N  = 6;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_PIN_CFG  = 12'h01e0; // pin_configuration
   localparam logic [ADDR_W-1:0] OFS_PIN_DDIR = 12'h01e4; // pin_data_direction
   localparam logic [ADDR_W-1:0] OFS_PIN_ISE  = 12'h01e8; // pin_interrupt_status_enable
   localparam logic [ADDR_W-1:0] OFS_TOP_STS  = 12'h0058; // top_interrupt_status (pin bit only)
   localparam logic [ADDR_W-1:0] OFS_TOP_EN   = 12'h005c; // top_interrupt_enable (pin bit only)

   // Field positions (low bit of each six-bit field; TOP_PIN_BIT is a single bit)
   localparam int POL_LSB  = 16; // pin_trigger_polarity in pin_configuration
   localparam int BUF_LSB  = 0;  // pin_buffer_type in pin_configuration
   localparam int DIR_LSB  = 16; // pin_direction in pin_data_direction
   localparam int DATA_LSB = 0;  // pin_data in pin_data_direction
   localparam int IEN_LSB  = 16; // per-pin enables in pin_interrupt_status_enable
   localparam int ISTS_LSB = 0;  // per-pin status in pin_interrupt_status_enable
   localparam int TOP_PIN_BIT = 12; // pin event in the top-level status and enable

   // Reset values
   localparam logic [PIN_N-1:0] RST_PIN_FIELD = 6'h00;
   localparam logic             RST_TOP_EN    = 1'b0;
   localparam logic [DATA_W-1:0] RD_IDLE      = 32'h0000_0000;

   // Timing: least trigger hold, rounded up to whole clock cycles
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PIN_HOLD_NS   = 40;
   localparam int PIN_HOLD_CYC  = (PIN_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_W        = 4;
   localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(PIN_HOLD_CYC);

endpackage : sgp_pkg
`default_nettype wire

// [src/sgp_sync.sv]
// Two-flip-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
`default_nettype none
module sgp_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync_out;

   // First stage feeds only the second stage
   always_comb begin
      next_meta     = async_in;
      next_sync_out = meta;
   end

   // Both stages clear on reset so the pins read low until sampled
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= next_meta;
         sync_out <= next_sync_out;
      end
   end

endmodule : sgp_sync
`default_nettype wire

// [src/sgp_gpio_port.sv]
// Six-pin general I/O port: registers, pin drivers, level interrupts and the pin event.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] Polarity bit per pin: 0 triggers on low level, 1 on high level.
// [R2] Buffer-type bit per pin: 0 open-drain driver, 1 push-pull driver.
// [R3] Open-drain output drives low for data zero and releases for data one.
// [R4] Direction bit per pin: 0 input, 1 output.
// [R5] An output pin shows the data bit software last wrote.
// [R6] Data read gives live pin for inputs, last written value for outputs.
// [R7] Writing one clears a pin status bit; writing zero leaves it alone.
// [R8] Status bits record triggers whether or not the pin enable is set.
// [R9] Enabled set status bits are ORed into one pin event.
// [R10] Interrupt asserts for pin events only if the top-level enable is also set.
// [R11] The outside source holds a trigger level longer than 40 ns.
// [R12] All pin fields reset to zero: inputs, open-drain, low trigger, no interrupts.
// [R13] Pin event reads at top status bit 12, enabled by top enable bit 12.
// [R14] Pin inputs pass two flip-flops before readback or interrupt detection.
// [R15] A pin still at its trigger level sets its status again after clearing.
module sgp_gpio_port (
   input  wire logic                         sys_clk,
   input  wire logic                         resetn,
   input  wire logic [sgp_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [sgp_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output var  logic [sgp_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic [sgp_pkg::PIN_N-1:0]    pin_in,
   output var  logic [sgp_pkg::PIN_N-1:0]    pin_out,
   output var  logic [sgp_pkg::PIN_N-1:0]    pin_oe,
   output var  logic                         pin_event,
   output var  logic                         irq
);
   import sgp_pkg::*;

   // Address match, used by both the write and the read decode
   function automatic logic sgp_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
      sgp_hit = (addr == ofs);
   endfunction : sgp_hit

   // Software-visible state
   logic [PIN_N-1:0]  pin_trigger_polarity;
   logic [PIN_N-1:0]  pin_buffer_type;
   logic [PIN_N-1:0]  pin_direction;
   logic [PIN_N-1:0]  pin_data;
   logic [PIN_N-1:0]  pin_int_enable;
   logic [PIN_N-1:0]  pin_int_status;
   logic              top_pin_enable;
   logic [PIN_N-1:0]  next_pin_trigger_polarity;
   logic [PIN_N-1:0]  next_pin_buffer_type;
   logic [PIN_N-1:0]  next_pin_direction;
   logic [PIN_N-1:0]  next_pin_data;
   logic [PIN_N-1:0]  next_pin_int_enable;
   logic [PIN_N-1:0]  next_pin_int_status;
   logic              next_top_pin_enable;

   // Pin side and interrupt outputs
   logic [PIN_N-1:0]  pin_sync;
   logic [PIN_N-1:0]  pin_qualified;
   logic [PIN_N-1:0]  next_pin_out;
   logic [PIN_N-1:0]  next_pin_oe;
   logic              next_pin_event;
   logic              next_irq;
   logic [DATA_W-1:0] next_reg_rdata;

   // Decoded strobes
   logic              wr_cfg;
   logic              wr_ddir;
   logic              wr_ise;
   logic              wr_top_en;
   logic              rd_cfg;
   logic              rd_ddir;
   logic              rd_ise;
   logic              rd_top_sts;
   logic              rd_top_en;

   // Register images as software sees them; reserved bits stay zero
   logic [DATA_W-1:0] cfg_image;
   logic [DATA_W-1:0] ddir_image;
   logic [DATA_W-1:0] ise_image;
   logic [DATA_W-1:0] top_sts_image;
   logic [DATA_W-1:0] top_en_image;

   // Pins cross into the clock domain before anything looks at them
   sgp_sync #(
      .WIDTH    (PIN_N)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in (pin_in),
      .sync_out (pin_sync)                                 // [R14]
   );

   // Write decode; an unmapped write is simply dropped
   always_comb begin
      wr_cfg    = reg_wr && sgp_hit(reg_addr, OFS_PIN_CFG);
      wr_ddir   = reg_wr && sgp_hit(reg_addr, OFS_PIN_DDIR);
      wr_ise    = reg_wr && sgp_hit(reg_addr, OFS_PIN_ISE);
      wr_top_en = reg_wr && sgp_hit(reg_addr, OFS_TOP_EN);
   end

   // Read decode; an unmapped read falls through to zero
   always_comb begin
      rd_cfg     = reg_rd && sgp_hit(reg_addr, OFS_PIN_CFG);
      rd_ddir    = reg_rd && sgp_hit(reg_addr, OFS_PIN_DDIR);
      rd_ise     = reg_rd && sgp_hit(reg_addr, OFS_PIN_ISE);
      rd_top_sts = reg_rd && sgp_hit(reg_addr, OFS_TOP_STS);
      rd_top_en  = reg_rd && sgp_hit(reg_addr, OFS_TOP_EN);
   end

   // Trigger qualification: one hold counter per pin
   genvar gi;
   generate
      for (gi = 0; gi < PIN_N; gi++) begin : g_pin
         logic [HOLD_W-1:0] hold_cnt;
         logic [HOLD_W-1:0] next_hold_cnt;
         logic              at_level;

         // Count cycles at the trigger level; a short glitch never reaches the limit
         always_comb begin
            at_level = (pin_sync[gi] == pin_trigger_polarity[gi]); // [R1]
            if (!at_level) begin
               next_hold_cnt = '0;
            end else if (hold_cnt == HOLD_MAX) begin
               next_hold_cnt = hold_cnt;                   // Saturate while the level holds
            end else begin
               next_hold_cnt = hold_cnt + 1'b1;
            end
         end

         // Counter register
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               hold_cnt <= '0;
            end else begin
               hold_cnt <= next_hold_cnt;
            end
         end

         // Level recognised once held for the least hold time
         assign pin_qualified[gi] = at_level && (hold_cnt == HOLD_MAX); // [R11]
      end
   endgenerate

   // Configuration register fields
   always_comb begin
      next_pin_trigger_polarity = pin_trigger_polarity;
      next_pin_buffer_type      = pin_buffer_type;
      if (wr_cfg) begin
         next_pin_trigger_polarity = reg_wdata[POL_LSB +: PIN_N]; // [R1]
         next_pin_buffer_type      = reg_wdata[BUF_LSB +: PIN_N]; // [R2]
      end
   end

   // Direction and data fields; data always stores the write, even for inputs
   always_comb begin
      next_pin_direction = pin_direction;
      next_pin_data      = pin_data;
      if (wr_ddir) begin
         next_pin_direction = reg_wdata[DIR_LSB +: PIN_N];  // [R4]
         next_pin_data      = reg_wdata[DATA_LSB +: PIN_N]; // [R5]
      end
   end

   // Enables and sticky status; a trigger in the clearing cycle wins over the clear
   always_comb begin
      next_pin_int_enable = pin_int_enable;
      next_pin_int_status = pin_int_status;
      if (wr_ise) begin
         next_pin_int_enable = reg_wdata[IEN_LSB +: PIN_N];
         next_pin_int_status = pin_int_status & ~reg_wdata[ISTS_LSB +: PIN_N]; // [R7]
      end
      // Set regardless of enables, and again while the level persists
      next_pin_int_status = next_pin_int_status | pin_qualified; // [R8] [R15]
   end

   // Top-level pin event enable
   always_comb begin
      next_top_pin_enable = top_pin_enable;
      if (wr_top_en) begin
         next_top_pin_enable = reg_wdata[TOP_PIN_BIT];      // [R13]
      end
   end

   // Configuration register; low-level trigger and open-drain after reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_trigger_polarity <= RST_PIN_FIELD;             // [R12]
         pin_buffer_type      <= RST_PIN_FIELD;
      end else begin
         pin_trigger_polarity <= next_pin_trigger_polarity;
         pin_buffer_type      <= next_pin_buffer_type;
      end
   end

   // Direction and data register; pins come up as undriven inputs
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_direction        <= RST_PIN_FIELD;             // [R12]
         pin_data             <= RST_PIN_FIELD;
      end else begin
         pin_direction        <= next_pin_direction;
         pin_data             <= next_pin_data;
      end
   end

   // Enable and status register; nothing pending and nothing enabled after reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_int_enable       <= RST_PIN_FIELD;             // [R12]
         pin_int_status       <= RST_PIN_FIELD;
      end else begin
         pin_int_enable       <= next_pin_int_enable;
         pin_int_status       <= next_pin_int_status;
      end
   end

   // Top-level pin event enable bit
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         top_pin_enable       <= RST_TOP_EN;
      end else begin
         top_pin_enable       <= next_top_pin_enable;
      end
   end

   // Pin drivers, computed from next values so pins follow the write edge
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         if (!next_pin_direction[i]) begin
            next_pin_out[i] = 1'b0;                         // Inputs are never driven
            next_pin_oe[i]  = 1'b0;                         // [R4]
         end else if (next_pin_buffer_type[i]) begin
            next_pin_out[i] = next_pin_data[i];             // Push-pull drives both levels [R2] [R5]
            next_pin_oe[i]  = 1'b1;
         end else begin
            next_pin_out[i] = 1'b0;                         // Open-drain only pulls low [R3]
            next_pin_oe[i]  = ~next_pin_data[i];
         end
      end
   end

   // Pin event and interrupt follow the status in the same cycle
   always_comb begin
      next_pin_event = |(next_pin_int_status & next_pin_int_enable); // [R9]
      next_irq       = next_pin_event && next_top_pin_enable;        // [R10]
   end

   // Register images; data of output pins shows the stored value, not the wire
   always_comb begin
      cfg_image     = RD_IDLE;
      ddir_image    = RD_IDLE;
      ise_image     = RD_IDLE;
      top_sts_image = RD_IDLE;
      top_en_image  = RD_IDLE;
      cfg_image[POL_LSB +: PIN_N]   = pin_trigger_polarity;
      cfg_image[BUF_LSB +: PIN_N]   = pin_buffer_type;
      ddir_image[DIR_LSB +: PIN_N]  = pin_direction;
      ddir_image[DATA_LSB +: PIN_N] = (pin_direction & pin_data) | (~pin_direction & pin_sync); // [R6]
      ise_image[IEN_LSB +: PIN_N]   = pin_int_enable;
      ise_image[ISTS_LSB +: PIN_N]  = pin_int_status;
      top_sts_image[TOP_PIN_BIT]    = pin_event;       // Read-only, clears with its source [R13]
      top_en_image[TOP_PIN_BIT]     = top_pin_enable;
   end

   // Read mux; a read that hits nothing returns zero, and the bus never waits
   always_comb begin
      next_reg_rdata = RD_IDLE;
      if (rd_cfg) begin
         next_reg_rdata = cfg_image;
      end else if (rd_ddir) begin
         next_reg_rdata = ddir_image;
      end else if (rd_ise) begin
         next_reg_rdata = ise_image;
      end else if (rd_top_sts) begin
         next_reg_rdata = top_sts_image;
      end else if (rd_top_en) begin
         next_reg_rdata = top_en_image;
      end
   end

   // Pin drive flops; every pin stays released through reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_out   <= RST_PIN_FIELD;
         pin_oe    <= RST_PIN_FIELD;
      end else begin
         pin_out   <= next_pin_out;
         pin_oe    <= next_pin_oe;
      end
   end

   // Interrupt flops; both follow the status register in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pin_event <= 1'b0;
         irq       <= 1'b0;
      end else begin
         pin_event <= next_pin_event;
         irq       <= next_irq;
      end
   end

   // Read data flop; the word stands for the single cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reg_rdata <= RD_IDLE;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule : sgp_gpio_port
`default_nettype wire

// [sim/sgp_port_chk_sva.sv]
// Checker for the six-pin port: bus reads, pin drive and interrupt gating.
`timescale 1ns/1ps
`default_nettype none
module sgp_port_chk (
   input wire logic                       sys_clk,
   input wire logic                       resetn,
   input wire logic [sgp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [sgp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [sgp_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [sgp_pkg::PIN_N-1:0]  pin_in,
   input wire logic [sgp_pkg::PIN_N-1:0]  pin_out,
   input wire logic [sgp_pkg::PIN_N-1:0]  pin_oe,
   input wire logic                       pin_event,
   input wire logic                       irq
);
   import sgp_pkg::*;
   logic [PIN_N-1:0] buf_sh, dir_sh, data_sh, ien_sh, next_buf, next_dir, next_data, next_ien;
   logic             top_en_sh, next_top_en, rd_map;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Shadow of the writable fields, so pin drive can be judged without seeing inside
   always_comb begin
      next_buf    = reg_wr && reg_addr == OFS_PIN_CFG ? reg_wdata[BUF_LSB +: PIN_N] : buf_sh;
      next_dir    = reg_wr && reg_addr == OFS_PIN_DDIR ? reg_wdata[DIR_LSB +: PIN_N] : dir_sh;
      next_data   = reg_wr && reg_addr == OFS_PIN_DDIR ? reg_wdata[DATA_LSB +: PIN_N] : data_sh;
      next_ien    = reg_wr && reg_addr == OFS_PIN_ISE ? reg_wdata[IEN_LSB +: PIN_N] : ien_sh;
      next_top_en = reg_wr && reg_addr == OFS_TOP_EN ? reg_wdata[TOP_PIN_BIT] : top_en_sh;
      rd_map      = reg_addr inside {OFS_PIN_CFG, OFS_PIN_DDIR, OFS_PIN_ISE, OFS_TOP_STS, OFS_TOP_EN};
   end
   // Shadow registers clear with the design's own reset
   always_ff @(posedge sys_clk) begin
      {buf_sh, dir_sh, data_sh, ien_sh, top_en_sh} <= resetn ?
         {next_buf, next_dir, next_data, next_ien, next_top_en} : '0;
   end
   rd_idle_a: assert property (reg_rdata != RD_IDLE |-> $past(reg_rd) && $past(rd_map))
      else $error("read data outside a mapped read");
   rd_top_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_TOP_STS |->
      reg_rdata[31:13] == 0 && reg_rdata[11:0] == 0) else $error("top status has stray bits");
   rd_ddir_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PIN_DDIR |->
      reg_rdata[DIR_LSB +: PIN_N] == $past(dir_sh) && ((reg_rdata[DATA_LSB +: PIN_N] ^ $past(data_sh))
      & $past(dir_sh)) == 0) else $error("direction or output data readback wrong");
   // Input bits read the pin as it stood three edges back, two synchroniser flops plus the read flop
   rd_pin_a: assert property ($past(reg_rd) && $past(reg_addr) == OFS_PIN_DDIR |->
      ((reg_rdata[DATA_LSB +: PIN_N] ^ $past(pin_in, 3)) & ~$past(dir_sh)) == 0)
      else $error("input pin readback wrong");
   drive_oe_a: assert property (pin_oe == (dir_sh & (buf_sh | ~data_sh)))
      else $error("pin enable wrong");
   drive_out_a: assert property (pin_out == (dir_sh & buf_sh & data_sh))
      else $error("pin drive value wrong");
   event_off_a: assert property (ien_sh == 0 && $past(ien_sh) == 0 |-> !pin_event)
      else $error("pin event with all enables off");
   irq_gate_a: assert property (irq |-> (pin_event || $past(pin_event)) && (top_en_sh || $past(top_en_sh)))
      else $error("interrupt without event and top enable");
   irq_on_a: assert property (pin_event && $past(pin_event) && top_en_sh && $past(top_en_sh) |-> irq)
      else $error("interrupt missing");
   cover property ($rose(irq));
   cover property (pin_event && !irq);
   cover property (|(pin_oe & ~pin_out));
endmodule : sgp_port_chk
`default_nettype wire

// [sim/sgp_pin_model.sv]
// Outside world on the six pins: a pull-up and a drivable source per pin.
`timescale 1ns/1ps
`default_nettype none
module sgp_pin_model (
   input  wire logic [sgp_pkg::PIN_N-1:0] pin_out,
   input  wire logic [sgp_pkg::PIN_N-1:0] pin_oe,
   input  wire logic [sgp_pkg::PIN_N-1:0] src_en,
   input  wire logic [sgp_pkg::PIN_N-1:0] src_val,
   output var  logic [sgp_pkg::PIN_N-1:0] pin_lvl
);
   import sgp_pkg::*;
   // Wire level per pin; a released pin takes the enabled source or else floats up, never keeps a stale value
   always_comb begin
      for (int i = 0; i < PIN_N; i++) begin
         if (pin_oe[i]) begin
            pin_lvl[i] = pin_out[i];
         end else if (src_en[i]) begin
            pin_lvl[i] = src_val[i]; // Bench holds levels for whole cycles
         end else begin
            pin_lvl[i] = 1'b1;
         end
      end
   end
endmodule : sgp_pin_model
`default_nettype wire

// [sim/test_sgp_gpio_port.sv]
// Self-checking bench for the six-pin port with its pin model and checker.
`timescale 1ns/1ps
`default_nettype none
module test_sgp_gpio_port;
   import sgp_pkg::*;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [PIN_N-1:0]  src_en = '0;
   logic [PIN_N-1:0]  src_val = '0;
   logic [DATA_W-1:0] reg_rdata, rd_val;
   logic [PIN_N-1:0]  pin_lvl, pin_out, pin_oe;
   logic              pin_event, irq;
   int                n_mismatch = 0;
   int                checked = 0;
   // 250 MHz system clock
   always #2 sys_clk = ~sys_clk;
   sgp_gpio_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_event(pin_event), .irq(irq));
   sgp_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .src_en(src_en), .src_val(src_val), .pin_lvl(pin_lvl));
   // Bus write; state settled on return
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // Bus read; data taken in the one cycle it stands
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask : rd
   task automatic cmp(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : cmp
   // Outside source change at an edge, then n cycles of hold
   task automatic src(input logic [PIN_N-1:0] en, input logic [PIN_N-1:0] val, input int n);
      @(posedge sys_clk);
      src_en <= en;
      src_val <= val;
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : src
   // Reset values; unmapped write ignored, unmapped read zero
   task automatic t_reset;
      cmp(32'h0000_0000, DATA_W'(pin_oe));
      wr(12'h01ec, 32'hffff_ffff);
      rd(OFS_PIN_CFG);
      cmp(32'h0000_0000, rd_val);
      rd(OFS_PIN_DDIR);
      cmp(32'h0000_003f, rd_val); // Pulled-up inputs read live
      rd(OFS_PIN_ISE);
      cmp(32'h0000_0000, rd_val);
      rd(OFS_TOP_EN);
      cmp(32'h0000_0000, rd_val);
      rd(12'h0100);
      cmp(32'h0000_0000, rd_val);
   endtask : t_reset
   // Push-pull, then open-drain against a low source, then back to input
   task automatic t_drive;
      wr(OFS_PIN_CFG, 32'h0000_003f);
      wr(OFS_PIN_DDIR, 32'h003f_002a);
      cmp(32'h0000_003f, DATA_W'(pin_oe));
      cmp(32'h0000_002a, DATA_W'(pin_out));
      wr(OFS_PIN_CFG, 32'h0000_0000);
      cmp(32'h0000_0015, DATA_W'(pin_oe));
      cmp(32'h0000_0000, DATA_W'(pin_out));
      src(6'h3f, 6'h00, 4);
      rd(OFS_PIN_DDIR);
      cmp(32'h003f_002a, rd_val);
      wr(OFS_PIN_DDIR, 32'h0000_002a);
      cmp(32'h0000_0000, DATA_W'(pin_oe));
      rd(OFS_PIN_DDIR);
      cmp(32'h0000_0000, rd_val);
   endtask : t_drive
   // High trigger, enables, top gate, clear while held, clear after release
   task automatic t_irq;
      src(6'h00, 6'h00, 4);
      wr(OFS_PIN_ISE, 32'h0000_003f);
      rd(OFS_PIN_ISE);
      cmp(32'h0000_0000, rd_val);
      wr(OFS_PIN_CFG, 32'h003f_0000);
      src(6'h00, 6'h00, 14);
      rd(OFS_PIN_ISE);
      cmp(32'h0000_003f, rd_val);
      cmp(32'h0000_0000, DATA_W'(pin_event));
      wr(OFS_PIN_ISE, 32'h0001_0000);
      src(6'h00, 6'h00, 2);
      cmp(32'h0000_0002, DATA_W'({pin_event, irq}));
      wr(OFS_TOP_EN, 32'h0000_1000);
      rd(OFS_TOP_STS);
      cmp(32'h0000_1000, rd_val);
      cmp(32'h0000_0001, DATA_W'(irq));
      wr(OFS_PIN_ISE, 32'h0001_0001);
      rd(OFS_PIN_ISE);
      cmp(32'h0001_003f, rd_val);
      src(6'h01, 6'h00, 4);
      wr(OFS_PIN_ISE, 32'h0001_0001);
      rd(OFS_PIN_ISE);
      cmp(32'h0001_003e, rd_val);
      cmp(32'h0000_0000, DATA_W'({pin_event, irq}));
   endtask : t_irq
   // A ten-cycle (40 ns) pulse is ignored, a longer held level is taken
   task automatic t_glitch;
      src(6'h01, 6'h01, 9);
      src(6'h01, 6'h00, 14);
      rd(OFS_PIN_ISE);
      cmp(32'h0001_003e, rd_val);
      src(6'h01, 6'h01, 14);
      rd(OFS_PIN_ISE);
      cmp(32'h0001_003f, rd_val);
      cmp(32'h0000_0001, DATA_W'(irq));
   endtask : t_glitch
   task automatic print_verdict;
      if (n_mismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   // Main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      #1;
      t_reset();
      t_drive();
      t_irq();
      t_glitch();
      print_verdict();
   end
   // Watchdog well beyond the roughly 145 cycles the reset and tests need
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      print_verdict();
   end
endmodule : test_sgp_gpio_port
bind sgp_gpio_port sgp_port_chk chk_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_event(pin_event), .irq(irq));
`default_nettype wire
